//--- hw/otpwm_pkg.sv
// Notes on behaviour
// - Enable bit and external reset input each pass two clock stages before use.
// - One-shot: first active edge after enable starts counting; later edges reset count.
// - After a reset edge the counter resumes by itself two clocks later.
// - Mode 01100 selects rising-edge start/reset, 01101 selects falling-edge.
// - One-shot period match zeroes the count and clears the enable bit.
// - With enable clear, external edges are ignored until software sets it.
// - Start edge and every reset edge drive the PWM output active.
// - Output goes inactive at pulse-width match, stays so until a free-run period match with nonzero duty, or an edge.
// - Duty is 10 bits across high/low registers, placed by the alignment bit.
// - Duty registers copy into the compare buffer only at a period match.
// - Time base is count plus two low bits: clock phase at 1:1, else prescaler.
// - PWM output is driven low when time base equals the buffered duty.
// - Resolution is log2 of four times (period plus one), ten bits at 255.
// - Buffered duty above the period leaves the PWM output unchanged.
package otpwm_pkg;

  // ==========================================================
  // Register bus
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } otpwm_bus_req_t;

  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_HI = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_LO = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_CMP_CTRL = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h7;

  // ==========================================================
  // Field positions and reset values
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_PS_LSB = 1;
  localparam int CTRL_OPS_LSB = 3;
  localparam int CMP_ALIGN_BIT = 0;
  localparam int CMP_EN_BIT = 1;
  localparam int STAT_PIN_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_RES_LSB = 2;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] MODE_RST = 5'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [1:0] CMP_RST = 2'h0;

  // ==========================================================
  // Modes, prescaler, timing
  localparam logic [4:0] MODE_ONESHOT_RISE = 5'h0c;
  localparam logic [4:0] MODE_ONESHOT_FALL = 5'h0d;

  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [1:0] PS_DIV16 = 2'h2;
  localparam logic [1:0] PS_DIV64 = 2'h3;

  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] RESTART_HOLD = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_RESTART = 3'b100
  } otpwm_state_t;

  // ==========================================================
  // Helpers
  function automatic logic [9:0] duty_assemble(input logic [7:0] hi, input logic [7:0] lo,
                                               input logic left);
    duty_assemble = left ? {hi, lo[7:6]} : {hi[1:0], lo};
  endfunction

  function automatic logic prescale_tick(input logic [5:0] pre, input logic [1:0] sel);
    unique case (sel)
      PS_DIV1: prescale_tick = 1'b1;
      PS_DIV4: prescale_tick = &pre[1:0];
      PS_DIV16: prescale_tick = &pre[3:0];
      PS_DIV64: prescale_tick = &pre[5:0];
    endcase
  endfunction

  function automatic logic [1:0] base_low(input logic [5:0] pre, input logic [1:0] phase,
                                          input logic [1:0] sel);
    unique case (sel)
      PS_DIV1: base_low = phase;
      PS_DIV4: base_low = pre[1:0];
      PS_DIV16: base_low = pre[3:2];
      PS_DIV64: base_low = pre[5:4];
    endcase
  endfunction

  function automatic logic [3:0] pwm_resolution(input logic [7:0] per);
    logic [8:0] p1;
    logic [3:0] r;
    p1 = {1'b0, per} + 9'h001;
    r = 4'h2;
    for (int i = 1; i <= 8; i++) begin
      if (p1 >= (9'h001 << i)) begin
        r = 4'(i + 2);
      end
    end
    pwm_resolution = r;
  endfunction

endpackage

//--- hw/otpwm_edge_sync.sv
`timescale 1ns/1ns
module otpwm_edge_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Pin and selection
  input wire logic async_in,
  input wire logic falling,
  // Result
  output logic edge_pulse
);

  logic s1_r, s2_r, s3_r;
  logic s1_nxt, s2_nxt, s3_nxt;

  // ==========================================================
  // Two-stage synchroniser, third stage only for edge detection
  always_comb begin
    s1_nxt = async_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  assign edge_pulse = falling ? (s3_r & ~s2_r) : (~s3_r & s2_r);

endmodule

//--- hw/otpwm_top.sv
`timescale 1ns/1ns
module otpwm_top (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire otpwm_pkg::otpwm_bus_req_t bus_req,
  output logic [otpwm_pkg::DATA_W-1:0] rdata_r,
  // External trigger
  input wire logic external_reset_input,
  // PWM pin
  output logic pwm_output_pin,
  output logic pwm_output_pin_oe
);

  // ==========================================================
  // Register file
  logic ctrl_on_r, ctrl_on_nxt;
  logic [1:0] clock_prescale_select_r, clock_prescale_select_nxt;
  logic [3:0] output_postscale_select_r, output_postscale_select_nxt;
  logic [4:0] mode_r, mode_nxt;
  logic [7:0] period_value_r, period_value_nxt;
  logic [7:0] duty_value_high_r, duty_value_high_nxt;
  logic [7:0] duty_value_low_r, duty_value_low_nxt;
  logic duty_alignment_select_r, duty_alignment_select_nxt;
  logic pwm_en_r, pwm_en_nxt;
  logic [otpwm_pkg::DATA_W-1:0] rdata_nxt;
  logic ctrl_wr;
  logic hw_off;

  // ==========================================================
  // Timer state
  otpwm_pkg::otpwm_state_t st_r, st_nxt;
  logic on_d1_r, on_d1_nxt;
  logic on_sync_r, on_sync_nxt;
  logic [7:0] timer_count_r, timer_count_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [5:0] pre_r, pre_nxt;
  logic [1:0] hold_r, hold_nxt;
  logic pwm_r, pwm_nxt;
  logic [9:0] duty_buf_r, duty_buf_nxt;

  logic ext_edge, oneshot, go, tick, match, rst_edge, wide, cmp_hit;
  logic [9:0] duty_val, time_base;

  assign ctrl_wr = bus_req.wr && (bus_req.addr == otpwm_pkg::ADDR_CTRL);
  assign oneshot = (mode_r == otpwm_pkg::MODE_ONESHOT_RISE)
                || (mode_r == otpwm_pkg::MODE_ONESHOT_FALL);
  assign duty_val = otpwm_pkg::duty_assemble(duty_value_high_r, duty_value_low_r,
                                             duty_alignment_select_r);

  otpwm_edge_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(external_reset_input),
    .falling(mode_r == otpwm_pkg::MODE_ONESHOT_FALL),
    .edge_pulse(ext_edge)
  );

  always_comb begin
    ctrl_on_nxt = ctrl_on_r;
    clock_prescale_select_nxt = clock_prescale_select_r;
    output_postscale_select_nxt = output_postscale_select_r;
    mode_nxt = mode_r;
    period_value_nxt = period_value_r;
    duty_value_high_nxt = duty_value_high_r;
    duty_value_low_nxt = duty_value_low_r;
    duty_alignment_select_nxt = duty_alignment_select_r;
    pwm_en_nxt = pwm_en_r;
    rdata_nxt = '0;
    // Software write beats the hardware clear of the enable bit
    if (hw_off) begin
      ctrl_on_nxt = 1'b0;
    end
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        otpwm_pkg::ADDR_CTRL: begin
          ctrl_on_nxt = bus_req.wdata[otpwm_pkg::CTRL_ON_BIT];
          clock_prescale_select_nxt = bus_req.wdata[otpwm_pkg::CTRL_PS_LSB +: 2];
          output_postscale_select_nxt = bus_req.wdata[otpwm_pkg::CTRL_OPS_LSB +: 4];
        end
        otpwm_pkg::ADDR_MODE: mode_nxt = bus_req.wdata[4:0];
        otpwm_pkg::ADDR_PERIOD: period_value_nxt = bus_req.wdata;
        otpwm_pkg::ADDR_DUTY_HI: duty_value_high_nxt = bus_req.wdata;
        otpwm_pkg::ADDR_DUTY_LO: duty_value_low_nxt = bus_req.wdata;
        otpwm_pkg::ADDR_CMP_CTRL: begin
          duty_alignment_select_nxt = bus_req.wdata[otpwm_pkg::CMP_ALIGN_BIT];
          pwm_en_nxt = bus_req.wdata[otpwm_pkg::CMP_EN_BIT];
        end
        default: ;
      endcase
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        otpwm_pkg::ADDR_CTRL: begin
          rdata_nxt[otpwm_pkg::CTRL_ON_BIT] = ctrl_on_r;
          rdata_nxt[otpwm_pkg::CTRL_PS_LSB +: 2] = clock_prescale_select_r;
          rdata_nxt[otpwm_pkg::CTRL_OPS_LSB +: 4] = output_postscale_select_r;
        end
        otpwm_pkg::ADDR_MODE: rdata_nxt[4:0] = mode_r;
        otpwm_pkg::ADDR_PERIOD: rdata_nxt = period_value_r;
        otpwm_pkg::ADDR_DUTY_HI: rdata_nxt = duty_value_high_r;
        otpwm_pkg::ADDR_DUTY_LO: rdata_nxt = duty_value_low_r;
        otpwm_pkg::ADDR_CMP_CTRL: begin
          rdata_nxt[otpwm_pkg::CMP_ALIGN_BIT] = duty_alignment_select_r;
          rdata_nxt[otpwm_pkg::CMP_EN_BIT] = pwm_en_r;
        end
        otpwm_pkg::ADDR_COUNT: rdata_nxt = timer_count_r;
        otpwm_pkg::ADDR_STATUS: begin
          rdata_nxt[otpwm_pkg::STAT_PIN_BIT] = pwm_r;
          rdata_nxt[otpwm_pkg::STAT_RUN_BIT] = (st_r != otpwm_pkg::ST_IDLE);
          rdata_nxt[otpwm_pkg::STAT_RES_LSB +: 4] =
            otpwm_pkg::pwm_resolution(period_value_r);
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_on_r <= otpwm_pkg::CTRL_RST[otpwm_pkg::CTRL_ON_BIT];
      clock_prescale_select_r <= otpwm_pkg::CTRL_RST[otpwm_pkg::CTRL_PS_LSB +: 2];
      output_postscale_select_r <= otpwm_pkg::CTRL_RST[otpwm_pkg::CTRL_OPS_LSB +: 4];
      mode_r <= otpwm_pkg::MODE_RST;
      period_value_r <= otpwm_pkg::PERIOD_RST;
      duty_value_high_r <= otpwm_pkg::DUTY_RST;
      duty_value_low_r <= otpwm_pkg::DUTY_RST;
      duty_alignment_select_r <= otpwm_pkg::CMP_RST[otpwm_pkg::CMP_ALIGN_BIT];
      pwm_en_r <= otpwm_pkg::CMP_RST[otpwm_pkg::CMP_EN_BIT];
      rdata_r <= '0;
    end else begin
      ctrl_on_r <= ctrl_on_nxt;
      clock_prescale_select_r <= clock_prescale_select_nxt;
      output_postscale_select_r <= output_postscale_select_nxt;
      mode_r <= mode_nxt;
      period_value_r <= period_value_nxt;
      duty_value_high_r <= duty_value_high_nxt;
      duty_value_low_r <= duty_value_low_nxt;
      duty_alignment_select_r <= duty_alignment_select_nxt;
      pwm_en_r <= pwm_en_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Timer, time base and PWM
  assign go = ctrl_on_r && on_sync_r;
  assign tick = (phase_r == otpwm_pkg::PHASE_LAST)
             && otpwm_pkg::prescale_tick(pre_r, clock_prescale_select_r);
  assign time_base = {timer_count_r,
                      otpwm_pkg::base_low(pre_r, phase_r, clock_prescale_select_r)};
  assign match = (st_r == otpwm_pkg::ST_RUN) && on_sync_r && tick
              && (timer_count_r == period_value_r);
  assign rst_edge = (st_r != otpwm_pkg::ST_IDLE) && on_sync_r && oneshot && ext_edge;
  // Duty beyond the whole period can never be met; pin is left alone
  assign wide = duty_buf_r > {period_value_r, 2'h3};
  assign cmp_hit = (time_base == duty_buf_r) && !wide;

  always_comb begin
    st_nxt = st_r;
    on_d1_nxt = ctrl_on_r;
    on_sync_nxt = on_d1_r;
    timer_count_nxt = timer_count_r;
    phase_nxt = phase_r + 2'h1;
    pre_nxt = pre_r;
    hold_nxt = hold_r;
    pwm_nxt = pwm_r;
    duty_buf_nxt = duty_buf_r;
    hw_off = 1'b0;
    if (phase_r == otpwm_pkg::PHASE_LAST) begin
      pre_nxt = pre_r + 6'h01;
    end
    unique case (st_r)
      otpwm_pkg::ST_IDLE: begin
        if (go && (!oneshot || ext_edge)) begin
          st_nxt = otpwm_pkg::ST_RUN;
          timer_count_nxt = '0;
          phase_nxt = '0;
          pre_nxt = '0;
          if (oneshot) begin
            pwm_nxt = 1'b1;
          end
        end
      end
      otpwm_pkg::ST_RUN: begin
        if (!on_sync_r) begin
          st_nxt = otpwm_pkg::ST_IDLE;
        end else if (rst_edge) begin
          st_nxt = otpwm_pkg::ST_RESTART;
          timer_count_nxt = '0;
          hold_nxt = otpwm_pkg::RESTART_HOLD;
          pwm_nxt = 1'b1;
        end else if (match) begin
          timer_count_nxt = '0;
          duty_buf_nxt = duty_val;
          if (oneshot) begin
            st_nxt = otpwm_pkg::ST_IDLE;
            hw_off = 1'b1;
          end else if (duty_val != '0) begin
            pwm_nxt = 1'b1;
          end
        end else begin
          if (tick) begin
            timer_count_nxt = timer_count_r + 8'h01;
          end
          if (cmp_hit) begin
            pwm_nxt = 1'b0;
          end
        end
      end
      otpwm_pkg::ST_RESTART: begin
        if (!on_sync_r) begin
          st_nxt = otpwm_pkg::ST_IDLE;
        end else if (rst_edge) begin
          hold_nxt = otpwm_pkg::RESTART_HOLD;
          pwm_nxt = 1'b1;
        end else if (hold_r == '0) begin
          st_nxt = otpwm_pkg::ST_RUN;
          phase_nxt = '0;
          pre_nxt = '0;
        end else begin
          hold_nxt = hold_r - 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= otpwm_pkg::ST_IDLE;
      on_d1_r <= 1'b0;
      on_sync_r <= 1'b0;
      timer_count_r <= '0;
      phase_r <= '0;
      pre_r <= '0;
      hold_r <= '0;
      pwm_r <= 1'b0;
      duty_buf_r <= '0;
    end else begin
      st_r <= st_nxt;
      on_d1_r <= on_d1_nxt;
      on_sync_r <= on_sync_nxt;
      timer_count_r <= timer_count_nxt;
      phase_r <= phase_nxt;
      pre_r <= pre_nxt;
      hold_r <= hold_nxt;
      pwm_r <= pwm_nxt;
      duty_buf_r <= duty_buf_nxt;
    end
  end

  assign pwm_output_pin = pwm_r;
  assign pwm_output_pin_oe = pwm_en_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence reset_edge_s;
    rst_edge && (st_r == otpwm_pkg::ST_RUN);
  endsequence

  sequence quiet_hold_s;
    (st_r == otpwm_pkg::ST_RESTART && on_sync_r && !ext_edge) [*2];
  endsequence

  a_enable_sync: assert property ($rose(ctrl_on_r) |=> !on_sync_r ##1 on_sync_r)
    else $error("enable not seen two clocks after set");
  a_start_edge: assert property (
    st_r == otpwm_pkg::ST_IDLE && go && oneshot && ext_edge
    |=> st_r == otpwm_pkg::ST_RUN && timer_count_r == '0 && pwm_r)
    else $error("start edge did not start timer");
  a_restart_hold: assert property (reset_edge_s ##1 quiet_hold_s |=> st_r == otpwm_pkg::ST_RUN)
    else $error("counter did not resume two clocks after reset edge");
  a_pwm_on_edge: assert property (reset_edge_s |=> pwm_r && timer_count_r == '0)
    else $error("reset edge did not activate output");
  a_halt_clear: assert property (match && oneshot && !rst_edge && !ctrl_wr
    |=> !ctrl_on_r && timer_count_r == '0 && st_r == otpwm_pkg::ST_IDLE)
    else $error("one-shot match did not halt");
  a_ignore_off: assert property (st_r == otpwm_pkg::ST_IDLE && !go
    |=> st_r == otpwm_pkg::ST_IDLE)
    else $error("edge accepted while disabled");
  a_duty_latch: assert property ($changed(duty_buf_r) |-> $past(match))
    else $error("duty buffer changed without period match");
  a_cmp_clear: assert property (st_r == otpwm_pkg::ST_RUN && on_sync_r && cmp_hit
    && !match && !rst_edge |=> !pwm_r)
    else $error("output not cleared at duty match");
  a_wide_keep: assert property (st_r == otpwm_pkg::ST_RUN && wide && !match && !rst_edge
    |=> $stable(pwm_r))
    else $error("output changed with duty beyond period");
  a_free_set: assert property (match && !oneshot && duty_val != '0
    |=> pwm_r && timer_count_r == '0 && st_r == otpwm_pkg::ST_RUN)
    else $error("free-run match did not set output");
  a_count_step: assert property (st_r == otpwm_pkg::ST_RUN && on_sync_r && tick && !match
    && !rst_edge |=> timer_count_r == $past(timer_count_r) + 8'h01)
    else $error("count did not advance on tick");

endmodule

//--- dv/otpwm_load_model.sv
`timescale 1ns/1ns
// ==========================================================
// Trigger source and PWM load
module otpwm_load_model (
  // Clock
  input wire logic clock,
  // Trigger control
  input wire logic fire,
  input wire logic falling,
  output logic trig,
  // Load side
  input wire logic pwm_in,
  output logic [15:0] pulse_len,
  output logic pulse_done,
  output logic [15:0] pulse_cnt
);
  logic [3:0] hold;
  logic [15:0] run;

  initial begin
    trig = 1'b0;
    hold = 4'h0;
    run = 16'h0;
    pulse_len = 16'h0;
    pulse_done = 1'b0;
    pulse_cnt = 16'h0;
  end

  // Active level held six clocks so the two-stage synchroniser cannot miss it
  always @(posedge clock) begin
    if (fire) begin
      hold <= 4'h6;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
    trig <= (fire || hold > 4'h1) ? !falling : falling;
  end

  // Measures every high pulse seen at the load
  always @(posedge clock) begin
    pulse_done <= 1'b0;
    if (pwm_in) begin
      run <= run + 16'h1;
    end else if (run != 16'h0) begin
      pulse_len <= run;
      pulse_done <= 1'b1;
      pulse_cnt <= pulse_cnt + 16'h1;
      run <= 16'h0;
    end
  end
endmodule

//--- dv/oneshot_timer_pwm_tb.sv
`timescale 1ns/1ns
module oneshot_timer_pwm_tb;
  logic clock;
  logic sys_rst;
  otpwm_pkg::otpwm_bus_req_t bus_req;
  logic [7:0] rdata_r;
  logic ext_trig;
  logic pwm_pin;
  logic pwm_oe;
  logic pin_wire;
  logic fire;
  logic falling;
  logic [15:0] pulse_len;
  logic pulse_done;
  logic [15:0] pulse_cnt;
  logic rd_d;
  logic [15:0] rd_q[$];
  logic [15:0] len_q[$];
  logic [15:0] exp_len;
  logic [15:0] duty;
  logic [15:0] base_cnt;
  logic [7:0] pers [6] = '{8'h00, 8'h01, 8'h03, 8'h64, 8'hfe, 8'hff};
  int mismatches;
  int total_checks;
  int cycles;

  // Pull-down on the pin while the output driver is off
  assign pin_wire = pwm_oe ? pwm_pin : 1'b0;

  otpwm_top otpwm_top_inst (
    .clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .rdata_r(rdata_r),
    .external_reset_input(ext_trig), .pwm_output_pin(pwm_pin), .pwm_output_pin_oe(pwm_oe)
  );
  otpwm_load_model otpwm_load_model_inst (
    .clock(clock), .fire(fire), .falling(falling), .trig(ext_trig), .pwm_in(pin_wire),
    .pulse_len(pulse_len), .pulse_done(pulse_done), .pulse_cnt(pulse_cnt)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back({8'h00, e});
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
  endtask

  task automatic trigger();
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask

  // Notes the length of the pulse that starts next
  task automatic expect_pulse(input logic [15:0] n);
    @(posedge pin_wire);
    len_q.push_back(n);
  endtask

  task automatic drain();
    for (int i = 0; i < 3000 && len_q.size() != 0; i++) begin
      @(posedge clock);
    end
    check(16'(len_q.size()), 16'h0000);
  endtask

  function automatic logic [3:0] res_bits(input logic [7:0] p);
    int n;
    n = p + 1;
    res_bits = 4'h2;
    while (n > 1) begin
      n = n / 2;
      res_bits++;
    end
  endfunction

  // Watches read data and pulse lengths; pulse lengths may be off by up to three cycles
  always @(posedge clock) begin
    if (rd_d) begin
      check({8'h00, rdata_r}, rd_q.pop_front());
    end
    if (pulse_done && len_q.size() != 0) begin
      exp_len = len_q.pop_front();
      check((pulse_len + 4 > exp_len && pulse_len < exp_len + 4) ? exp_len : pulse_len,
            exp_len);
    end
    rd_d <= bus_req.rd;
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    sys_rst = 1'b1;
    bus_req = '0;
    fire = 1'b0;
    falling = 1'b0;
    rd_d = 1'b0;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    base_cnt = 16'($urandom(32'ha803));
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    rd(otpwm_pkg::ADDR_CTRL, 8'h00);
    rd(otpwm_pkg::ADDR_PERIOD, 8'hff);
    rd(otpwm_pkg::ADDR_DUTY_HI, 8'h00);
    rd(otpwm_pkg::ADDR_STATUS, 8'h28);
    rd(4'hf, 8'h00);
    wr(otpwm_pkg::ADDR_COUNT, 8'h5a);
    rd(otpwm_pkg::ADDR_COUNT, 8'h00);
    check({15'h0000, pwm_oe}, 16'h0000);
    foreach (pers[i]) begin
      wr(otpwm_pkg::ADDR_PERIOD, pers[i]);
      rd(otpwm_pkg::ADDR_STATUS, {2'b00, res_bits(pers[i]), 2'b00});
    end
    $display("test registers done");
    // Free run, right aligned random duty, then left aligned
    wr(otpwm_pkg::ADDR_PERIOD, 8'h0f);
    wr(otpwm_pkg::ADDR_CMP_CTRL, 8'h02);
    @(posedge clock);
    check({15'h0000, pwm_oe}, 16'h0001);
    duty = 16'(8 + $urandom % 40);
    wr(otpwm_pkg::ADDR_DUTY_HI, {6'h00, duty[9:8]});
    wr(otpwm_pkg::ADDR_DUTY_LO, duty[7:0]);
    wr(otpwm_pkg::ADDR_CTRL, 8'h01);
    repeat (150) @(posedge clock);
    expect_pulse(duty);
    drain();
    wr(otpwm_pkg::ADDR_CMP_CTRL, 8'h03);
    wr(otpwm_pkg::ADDR_DUTY_HI, duty[9:2]);
    wr(otpwm_pkg::ADDR_DUTY_LO, {duty[1:0], 6'h00});
    repeat (150) @(posedge clock);
    expect_pulse(duty);
    drain();
    // A write in mid-pulse must wait for the period match
    @(posedge pin_wire);
    len_q.push_back(duty);
    len_q.push_back(16'd48);
    wr(otpwm_pkg::ADDR_DUTY_LO, 8'h00);
    wr(otpwm_pkg::ADDR_DUTY_HI, 8'h0c);
    drain();
    $display("test free run done");
    wr(otpwm_pkg::ADDR_CTRL, 8'h03);
    repeat (600) @(posedge clock);
    expect_pulse(16'd192);
    drain();
    // Disable first so the count restarts at zero under the shorter period
    wr(otpwm_pkg::ADDR_CTRL, 8'h00);
    wr(otpwm_pkg::ADDR_PERIOD, 8'h00);
    wr(otpwm_pkg::ADDR_DUTY_HI, 8'h00);
    wr(otpwm_pkg::ADDR_DUTY_LO, 8'h80);
    wr(otpwm_pkg::ADDR_CTRL, 8'h05);
    repeat (200) @(posedge clock);
    expect_pulse(16'd32);
    drain();
    wr(otpwm_pkg::ADDR_CTRL, 8'h07);
    repeat (600) @(posedge clock);
    expect_pulse(16'd128);
    drain();
    wr(otpwm_pkg::ADDR_PERIOD, 8'h0f);
    wr(otpwm_pkg::ADDR_DUTY_LO, 8'h00);
    wr(otpwm_pkg::ADDR_CTRL, 8'h01);
    wr(otpwm_pkg::ADDR_DUTY_HI, 8'h20);
    repeat (300) @(posedge clock);
    base_cnt = pulse_cnt;
    repeat (200) @(posedge clock);
    check(pulse_cnt, base_cnt);
    check({15'h0000, pin_wire}, 16'h0001);
    wr(otpwm_pkg::ADDR_DUTY_HI, 8'h05);
    repeat (200) @(posedge clock);
    @(negedge pin_wire);
    wr(otpwm_pkg::ADDR_CTRL, 8'h00);
    $display("test prescaler and overrange done");
    // One-shot in both edge modes
    for (int m = 0; m < 2; m++) begin
      falling <= (m == 1);
      wr(otpwm_pkg::ADDR_MODE, 8'((m == 1) ? otpwm_pkg::MODE_ONESHOT_FALL
                                           : otpwm_pkg::MODE_ONESHOT_RISE));
      wr(otpwm_pkg::ADDR_CTRL, 8'h01);
      repeat (4) @(posedge clock);
      trigger();
      expect_pulse(16'd20);
      drain();
      repeat (80) @(posedge clock);
      rd(otpwm_pkg::ADDR_CTRL, 8'h00);
      rd(otpwm_pkg::ADDR_COUNT, 8'h00);
      rd(otpwm_pkg::ADDR_STATUS, 8'h18);
      base_cnt = pulse_cnt;
      trigger();
      repeat (40) @(posedge clock);
      check(pulse_cnt, base_cnt);
    end
    $display("test one-shot done");
    // Reset edge before the period match restarts the pulse
    wr(otpwm_pkg::ADDR_CTRL, 8'h01);
    repeat (4) @(posedge clock);
    trigger();
    expect_pulse(16'd20);
    drain();
    repeat (10) @(posedge clock);
    trigger();
    expect_pulse(16'd22);
    drain();
    repeat (90) @(posedge clock);
    rd(otpwm_pkg::ADDR_CTRL, 8'h00);
    repeat (3) @(posedge clock);
    $display("test restart done");
    finish_test();
  end
endmodule
